// ### design/dakrs_core.sv
// Shaped amplitude keying and RAM-driven tuning sequencer with a Wishbone register bank.
`timescale 1ns/10ps

// Contract
// - An enable bit in control register one turns shaped keying on or off.
// - A second control bit selects automatic or manual keying.
// - Automatic mode: 14-bit counter rises while keying pin high, falls while low.
// - Core samples are multiplied by the unsigned 14-bit scale factor.
// - Top two scale field bits pick step size 1, 2, 4 or 8.
// - Automatic ramp never exceeds the programmed amplitude scale value.
// - 8-bit ramp timer counts down, reloading at one while enabled.
// - With reload bit set, update strobe or profile change reloads ramp timer.
// - Keying toggle, update rising edge or profile change reloads timer early.
// - Enabling automatic keying forces a ramp timer reload.
// - Manual mode uses the amplitude scale register directly as scale factor.
// - Single-tone feeds tuning word zero, changed only after update strobe.
// - Update strobe, or a profile change outside bidirectional mode, ends the sweep and starts the next.
// - Destination bit routes RAM to frequency word or phase word.
// - Mode field decodes five modes; codes 101 to 111 act as direct switch.
// - Direct switch outputs the beginning-address word without stepping.
// - Profile pins select words in direct switch; phase uses RAM upper bits only.
// - Ramp-up loads begin and rate, steps at expiry to final, then no-dwell.
// - Bidirectional mode uses only profile zero's segment; low pin is direction.
// - Bidirectional expiry steps up or down; direction change steps and reloads.
// - Direction toggles never transfer registers; sweep stalls at its end address.
// - Update strobe copies all buffered registers into the active registers.
module dakrs_core
  import dakrs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        shaped_keying_input_i,
  input  wire logic        profile_select_low_i,
  input  wire logic        profile_select_high_i,
  input  wire logic        io_update_i,
  input  wire logic [13:0] core_sample_i,
  output logic      [31:0] frequency_tuning_word_o,
  output logic      [13:0] phase_offset_word_o,
  output logic      [13:0] scaled_sample_o
);

  logic [31:0]       buf_r [BANK_WORDS];
  logic [31:0]       act_r [BANK_WORDS];
  logic [31:0]       ram_mem [RAM_WORDS];
  logic [RAM_AW-1:0] ram_ptr_r;
  logic [3:0]        sync1_r;
  logic [3:0]        sync2_r;
  logic [3:0]        prev_r;
  logic              auto_prev_r;
  logic              upd_act_r;
  logic [7:0]        amp_tmr_r;
  logic [7:0]        amp_tmr_nxt;
  logic [SF_W-1:0]   sf_r;
  logic [SF_W-1:0]   sf_nxt;
  logic [SF_W-1:0]   scale_r;
  logic [RAM_AW-1:0] ram_addr_r;
  logic [RAM_AW-1:0] ram_addr_nxt;
  logic [15:0]       ram_tmr_r;
  logic [15:0]       ram_tmr_nxt;
  logic              ram_run_r;
  logic              ram_run_nxt;
  logic [31:0]       ram_q_r;

  // Bus decode: one request is taken per cycle before the acknowledge.
  wire       wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [3:0] wb_idx   = wb_adr_i[5:2];
  wire       wb_upper = |wb_adr_i[7:6];
  wire       bank_hit = ~wb_upper & (int'(wb_idx) < BANK_WORDS);
  wire       wr_bank  = wb_req & wb_we_i & bank_hit;
  wire       wr_ptr   = wb_req & wb_we_i & ~wb_upper & (wb_idx == IDX_RAMPTR);
  wire       wr_dat   = wb_req & wb_we_i & ~wb_upper & (wb_idx == IDX_RAMDAT);

  // Pin events, taken only from the second synchroniser stage.
  wire key_tog  = sync2_r[PIN_KEY] ^ prev_r[PIN_KEY];
  wire psl_chg  = sync2_r[PIN_PSL] ^ prev_r[PIN_PSL];
  wire psh_chg  = sync2_r[PIN_PSH] ^ prev_r[PIN_PSH];
  wire prof_chg = psl_chg | psh_chg;
  wire upd_rise = sync2_r[PIN_UPD] & ~prev_r[PIN_UPD];

  // Active control bits.
  wire [31:0] ctrl      = act_r[IDX_CTRL];
  wire [15:0] amplitude_scale_field       = act_r[IDX_ASF][15:0];
  wire [7:0]  amp_rate  = act_r[IDX_RATE][7:0];
  wire        osk_en    = ctrl[CR_OSK_EN];
  wire        osk_auto  = ctrl[CR_OSK_AUTO];
  wire        reload_up = ctrl[CR_RELOAD];
  wire        ram_en    = ctrl[CR_RAM_EN];
  wire        ram_dest  = ctrl[CR_RAM_DEST];
  wire        no_dwell  = ctrl[CR_NO_DWELL];

  // Update reloads act a cycle after the bank copy, so they load the new rate.
  wire auto_on   = osk_en & osk_auto;
  wire auto_rise = auto_on & ~auto_prev_r;
  wire amp_force = key_tog | upd_act_r | prof_chg
                 | (reload_up & (upd_act_r | prof_chg))
                 | auto_rise;
  wire amp_tick  = auto_on & ~amp_force & (amp_tmr_r <= 8'h01);

  // Step size doubles with each code of the top scale field bits.
  wire [SF_W-1:0] sf_step  = SF_W'(1) << amplitude_scale_field[15:14];
  wire [SF_W-1:0] sf_limit = amplitude_scale_field[SF_W-1:0];
  wire [SF_W:0]   sf_sum   = {1'b0, sf_r} + {1'b0, sf_step};
  wire [SF_W-1:0] sf_up    = (sf_sum > {1'b0, sf_limit}) ? sf_limit : sf_sum[SF_W-1:0];
  wire [SF_W-1:0] sf_down  = (sf_r > sf_step) ? (sf_r - sf_step) : '0;

  // Scale source: bypass, manual register or automatic counter.
  wire [SF_W-1:0] scale_sel = !osk_en ? SF_FULL :
                              (osk_auto ? sf_r : sf_limit);
  wire [27:0]     product   = 28'(core_sample_i) * 28'(scale_r);

  // Segment selection; bidirectional mode on profile zero pins the segment.
  wire         bidir    = dakrs_mode_dec(act_r[IDX_SCW][7:5]) == MODE_BIDIR;
  wire [1:0]   prof     = bidir ? 2'b00 : {sync2_r[PIN_PSH], sync2_r[PIN_PSL]};
  wire [3:0]   scw_lo_i = IDX_SCW + {1'b0, prof, 1'b0};
  wire [3:0]   scw_hi_i = scw_lo_i + 4'h1;
  dakrs_scw_t  seg;
  dakrs_mode_t mode;
  assign seg  = dakrs_scw_dec(act_r[scw_lo_i], act_r[scw_hi_i]);
  assign mode = dakrs_mode_dec(seg.mode);

  // Update restarts a cycle late so the sweep starts from the newly copied segment.
  wire ram_trig = upd_act_r | (~bidir & prof_chg);
  wire dir_up   = sync2_r[PIN_PSL];
  wire dir_chg  = bidir & psl_chg;
  wire ram_tick = ram_run_r & (ram_tmr_r <= 16'h0001);
  wire at_fin   = ram_addr_r == seg.fin;
  wire at_beg   = ram_addr_r == seg.beg;
  wire at_end   = dir_up ? at_fin : at_beg;
  wire [RAM_AW-1:0] addr_inc  = ram_addr_r + RAM_AW'(1);
  wire [RAM_AW-1:0] addr_dec  = ram_addr_r - RAM_AW'(1);
  wire [RAM_AW-1:0] addr_step = at_end ? ram_addr_r : (dir_up ? addr_inc : addr_dec);

  // Amplitude ramp timer and scale counter next values.
  always_comb
  begin
    amp_tmr_nxt = amp_tmr_r - 8'h01;
    sf_nxt      = sf_r;
    if (!auto_on || amp_force || amp_tmr_r <= 8'h01)
      amp_tmr_nxt = amp_rate;
    if (amp_tick)
      sf_nxt = sync2_r[PIN_KEY] ? sf_up : sf_down;
  end

  // RAM address generator next values.
  always_comb
  begin
    ram_addr_nxt = ram_addr_r;
    ram_tmr_nxt  = ram_tmr_r;
    ram_run_nxt  = ram_run_r;
    if (!ram_en)
    begin
      ram_run_nxt = 1'b0;
    end
    else if (ram_trig)
    begin
      ram_addr_nxt = seg.beg;
      ram_tmr_nxt  = seg.rate;
      ram_run_nxt  = (mode != MODE_DIRECT);
    end
    else
    begin
      unique case (mode)
        MODE_DIRECT:
        begin
          ram_addr_nxt = seg.beg;
          ram_run_nxt  = 1'b0;
        end
        MODE_BIDIR:
        begin
          if (dir_chg || ram_tick)
          begin
            ram_addr_nxt = addr_step;
            ram_tmr_nxt  = seg.rate;
            ram_run_nxt  = 1'b1;
          end
          else
            ram_tmr_nxt = ram_tmr_r - 16'h0001;
        end
        MODE_UP, MODE_CBIDIR, MODE_RECIRC:
        begin
          if (ram_tick)
          begin
            ram_tmr_nxt = seg.rate;
            if (at_fin)
            begin
              ram_run_nxt = 1'b0;
              if (no_dwell)
                ram_addr_nxt = seg.beg;
            end
            else
            begin
              ram_addr_nxt = addr_inc;
              ram_run_nxt  = (addr_inc != seg.fin) | no_dwell;
            end
          end
          else if (ram_run_r)
            ram_tmr_nxt = ram_tmr_r - 16'h0001;
        end
      endcase
    end
  end

  // Pin synchronisers and edge history.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      prev_r  <= 4'h0;
    end
    else
    begin
      sync1_r <= {io_update_i, profile_select_high_i, profile_select_low_i,
                  shaped_keying_input_i};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Buffered bank written by software, active bank loaded on the update strobe.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      for (int i = 0; i < BANK_WORDS; i++)
      begin
        buf_r[i] <= 32'h0;
        act_r[i] <= 32'h0;
      end
    else
      for (int i = 0; i < BANK_WORDS; i++)
      begin
        if (wr_bank && int'(wb_idx) == i)
          buf_r[i] <= dakrs_merge(buf_r[i], wb_dat_i, wb_sel_i) & dakrs_mask(4'(i));
        if (upd_rise)
          act_r[i] <= buf_r[i];
      end
  end

  // Bus answer: acknowledge one cycle after the request, drop it next cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i)
        wb_dat_o <= bank_hit ? buf_r[wb_idx] :
                    (~wb_upper && wb_idx == IDX_RAMPTR) ? 32'(ram_ptr_r) :
                    (~wb_upper && wb_idx == IDX_STATUS) ?
                      {6'h0, ram_addr_r, 2'h0, sf_r} : 32'h0;
    end
  end

  // RAM loading port: data writes land at the pointer, which then advances.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ram_ptr_r <= '0;
    else if (wr_ptr)
      ram_ptr_r <= wb_dat_i[RAM_AW-1:0];
    else if (wr_dat)
      ram_ptr_r <= ram_ptr_r + RAM_AW'(1);
  end

  // RAM array has no reset; its read port follows the sweep address.
  always_ff @(posedge clk_i)
  begin
    if (wr_dat)
      ram_mem[ram_ptr_r] <= wb_dat_i;
    ram_q_r <= ram_mem[ram_addr_r];
  end

  // Amplitude and sweep state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      auto_prev_r <= 1'b0;
      upd_act_r   <= 1'b0;
      amp_tmr_r   <= 8'h0;
      sf_r        <= '0;
      ram_addr_r  <= '0;
      ram_tmr_r   <= 16'h0;
      ram_run_r   <= 1'b0;
    end
    else
    begin
      auto_prev_r <= auto_on;
      upd_act_r   <= upd_rise;
      amp_tmr_r   <= amp_tmr_nxt;
      sf_r        <= sf_nxt;
      ram_addr_r  <= ram_addr_nxt;
      ram_tmr_r   <= ram_tmr_nxt;
      ram_run_r   <= ram_run_nxt;
    end
  end

  // Output words. The extra RAM pipeline stage costs one cycle of latency.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scale_r                 <= '0;
      scaled_sample_o         <= '0;
      frequency_tuning_word_o <= 32'h0;
      phase_offset_word_o     <= '0;
    end
    else
    begin
      scale_r                 <= scale_sel;
      scaled_sample_o         <= product[27:14];
      frequency_tuning_word_o <= (ram_en && !ram_dest) ? ram_q_r :
                                 act_r[IDX_FTW];
      phase_offset_word_o     <= (ram_en && ram_dest) ? ram_q_r[31:POW_LSB] :
                                 act_r[IDX_POW][13:0];
    end
  end

  property p_manual_scale;
    @(posedge clk_i) disable iff (rst_i)
      osk_en && !osk_auto |=> scale_r == $past(sf_limit);
  endproperty
  a_manual_scale: assert property (p_manual_scale) else $error("manual scale wrong");

  property p_product;
    @(posedge clk_i) disable iff (rst_i)
      ##1 scaled_sample_o == 14'(($past(28'(core_sample_i)) * $past(28'(scale_r))) >> 14);
  endproperty
  a_product: assert property (p_product) else $error("scaled sample wrong");
  property p_early_reload;
    @(posedge clk_i) disable iff (rst_i)
      key_tog || upd_act_r || prof_chg |=> amp_tmr_r == $past(amp_rate);
  endproperty
  a_early_reload: assert property (p_early_reload) else $error("no early reload");
  property p_count_down;
    @(posedge clk_i) disable iff (rst_i)
      auto_on && !amp_force && amp_tmr_r > 8'h01 |=> amp_tmr_r == $past(amp_tmr_r) - 8'h01;
  endproperty
  a_count_down: assert property (p_count_down) else $error("ramp timer miscount");
  property p_enable_reload;
    @(posedge clk_i) disable iff (rst_i)
      $rose(auto_on) |-> ##1 amp_tmr_r == $past(amp_rate);
  endproperty
  a_enable_reload: assert property (p_enable_reload) else $error("no reload on enable");
  property p_sf_limit;
    @(posedge clk_i) disable iff (rst_i)
      amp_tick && sync2_r[PIN_KEY] |=> sf_r <= $past(sf_limit);
  endproperty
  a_sf_limit: assert property (p_sf_limit) else $error("scale above limit");
  property p_sf_floor;
    @(posedge clk_i) disable iff (rst_i)
      amp_tick && !sync2_r[PIN_KEY] |=> sf_r <= $past(sf_r);
  endproperty
  a_sf_floor: assert property (p_sf_floor) else $error("scale wrapped");
  property p_update_copy;
    @(posedge clk_i) disable iff (rst_i)
      upd_rise |=> act_r[IDX_CTRL] == $past(buf_r[IDX_CTRL]);
  endproperty
  a_update_copy: assert property (p_update_copy) else $error("update copy missed");
  property p_ramp_step;
    @(posedge clk_i) disable iff (rst_i)
      ram_en && !ram_trig && mode == MODE_UP && ram_tick && !at_fin
        |=> ram_addr_r == $past(addr_inc);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp step missed");

  property p_direct_hold;
    @(posedge clk_i) disable iff (rst_i)
      ram_en && mode == MODE_DIRECT |=> ram_addr_r == $past(seg.beg);
  endproperty
  a_direct_hold: assert property (p_direct_hold) else $error("direct address wrong");

  property p_single_tone;
    @(posedge clk_i) disable iff (rst_i)
      !ram_en |=> frequency_tuning_word_o == $past(act_r[IDX_FTW]);
  endproperty
  a_single_tone: assert property (p_single_tone) else $error("tone word wrong");

  c_auto_ramp: cover property (@(posedge clk_i) disable iff (rst_i) amp_tick ##1 amp_tick);
  c_ramp_end:  cover property (@(posedge clk_i) disable iff (rst_i)
                               mode == MODE_UP && ram_tick && at_fin);
  c_bidir_dir: cover property (@(posedge clk_i) disable iff (rst_i) ram_en && dir_chg);

endmodule : dakrs_core

// ### include/dakrs_pkg.sv
// Shared constants, types and helpers for the amplitude keying and RAM sweep block.
package dakrs_pkg;

  // Register word indices (byte address = index * 4) on the Wishbone slave.
  localparam logic [3:0] IDX_CTRL    = 4'h0;
  localparam logic [3:0] IDX_ASF     = 4'h1;
  localparam logic [3:0] IDX_RATE    = 4'h2;
  localparam logic [3:0] IDX_FTW     = 4'h3;
  localparam logic [3:0] IDX_POW     = 4'h4;
  localparam logic [3:0] IDX_SCW     = 4'h5;
  localparam logic [3:0] IDX_RAMPTR  = 4'hD;
  localparam logic [3:0] IDX_RAMDAT  = 4'hE;
  localparam logic [3:0] IDX_STATUS  = 4'hF;
  localparam int         BANK_WORDS  = 13;

  // Writable bit masks; masked-off bits read as zero.
  localparam logic [31:0] MASK_CTRL   = 32'hC7000004;
  localparam logic [31:0] MASK_ASF    = 32'h0000FFFF;
  localparam logic [31:0] MASK_RATE   = 32'h000000FF;
  localparam logic [31:0] MASK_FTW    = 32'hFFFFFFFF;
  localparam logic [31:0] MASK_POW    = 32'h00003FFF;
  localparam logic [31:0] MASK_SCW_LO = 32'h0FFFFFE0;
  localparam logic [31:0] MASK_SCW_HI = 32'h0000FFFF;

  // Bit positions inside control_register_one.
  localparam int CR_RAM_EN   = 31;
  localparam int CR_RAM_DEST = 30;
  localparam int CR_RELOAD   = 26;
  localparam int CR_OSK_EN   = 25;
  localparam int CR_OSK_AUTO = 24;
  localparam int CR_NO_DWELL = 2;

  // Scale and RAM geometry.
  localparam int          SF_W      = 14;
  localparam logic [13:0] SF_FULL   = 14'h3FFF;
  localparam int          RAM_AW    = 10;
  localparam int          RAM_WORDS = 1024;
  localparam int          POW_LSB   = 18;

  // Pin bit positions inside the synchronised pin vector.
  localparam int PIN_KEY = 0;
  localparam int PIN_PSL = 1;
  localparam int PIN_PSH = 2;
  localparam int PIN_UPD = 3;

  // RAM segment modes, one-hot.
  typedef enum logic [4:0] {
    MODE_DIRECT = 5'b00001,
    MODE_UP     = 5'b00010,
    MODE_BIDIR  = 5'b00100,
    MODE_CBIDIR = 5'b01000,
    MODE_RECIRC = 5'b10000
  } dakrs_mode_t;

  // Fields of one profile's segment control word pair.
  typedef struct packed {
    logic [15:0] rate;
    logic [9:0]  fin;
    logic [9:0]  beg;
    logic [2:0]  mode;
  } dakrs_scw_t;

  // Decodes the three-bit mode field; unused codes fall back to direct switch.
  function automatic dakrs_mode_t dakrs_mode_dec(input logic [2:0] code);
    case (code)
      3'h1:    return MODE_UP;
      3'h2:    return MODE_BIDIR;
      3'h3:    return MODE_CBIDIR;
      3'h4:    return MODE_RECIRC;
      default: return MODE_DIRECT;
    endcase
  endfunction : dakrs_mode_dec

  // Splits a low/high word pair into segment fields.
  function automatic dakrs_scw_t dakrs_scw_dec(input logic [31:0] lo, input logic [31:0] hi);
    return '{rate: hi[15:0], fin: lo[27:18], beg: lo[17:8], mode: lo[7:5]};
  endfunction : dakrs_scw_dec

  // Writable mask of a bank word.
  function automatic logic [31:0] dakrs_mask(input logic [3:0] idx);
    case (idx)
      IDX_CTRL: return MASK_CTRL;
      IDX_ASF:  return MASK_ASF;
      IDX_RATE: return MASK_RATE;
      IDX_FTW:  return MASK_FTW;
      IDX_POW:  return MASK_POW;
      default:  return (idx[0] == IDX_SCW[0]) ? MASK_SCW_LO : MASK_SCW_HI;
    endcase
  endfunction : dakrs_mask

  // Merges write data into an old word under the byte selects.
  function automatic logic [31:0] dakrs_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
      if (sel[b]) res[8*b +: 8] = new_w[8*b +: 8];
    return res;
  endfunction : dakrs_merge

endpackage : dakrs_pkg

// ### tb/dakrs_ctrl_model.sv
// Controller model that drives the keying, profile and update pins.
`timescale 1ns/10ps
module dakrs_ctrl_model
(
  input  wire logic clk_i,
  output logic      key_o,
  output logic      psl_o,
  output logic      psh_o,
  output logic      upd_o
);
  // Pins idle low until the bench moves them.
  initial
  begin
    key_o = 1'b0;
    psl_o = 1'b0;
    psh_o = 1'b0;
    upd_o = 1'b0;
  end

  // Levels move together just after an edge.
  task automatic pins(input logic k, input logic l, input logic h);
    @(posedge clk_i);
    key_o <= k;
    psl_o <= l;
    psh_o <= h;
  endtask : pins

  // Held four cycles so the synchroniser cannot miss the rising edge.
  task automatic update();
    @(posedge clk_i);
    upd_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    upd_o <= 1'b0;
  endtask : update
endmodule : dakrs_ctrl_model

// ### tb/tb_dakrs_core.sv
// Self-checking bench for the amplitude keying and RAM sweep block.
`timescale 1ns/10ps
module tb_dakrs_core
  import dakrs_pkg::*;
;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] e;
  } dakrs_row_t;

  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        wb_cyc  = 1'b0;
  logic        wb_stb  = 1'b0;
  logic        wb_we   = 1'b0;
  logic [7:0]  wb_adr  = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        key, psl, psh, upd;
  logic [13:0] core    = 14'h3FFF;
  logic [31:0] frequency_tuning_word, q, prev;
  logic [13:0] phase_offset_word, scl;
  int          fail_count = 0;
  int          n_checks   = 0;
  dakrs_row_t  rows [7] = '{'{8'h00, MASK_CTRL}, '{8'h04, MASK_ASF}, '{8'h08, MASK_RATE},
    '{8'h10, MASK_POW}, '{8'h14, MASK_SCW_LO}, '{8'h18, MASK_SCW_HI}, '{8'h40, 32'h0}};

  dakrs_core dakrs_core_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .shaped_keying_input_i(key), .profile_select_low_i(psl),
    .profile_select_high_i(psh), .io_update_i(upd), .core_sample_i(core),
    .frequency_tuning_word_o(frequency_tuning_word), .phase_offset_word_o(phase_offset_word), .scaled_sample_o(scl));
  dakrs_ctrl_model dakrs_ctrl_model_inst (.clk_i(clk_i), .key_o(key), .psl_o(psl),
    .psh_o(psh), .upd_o(upd));

  // 100 ns clock.
  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic results();
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; a slave that never answers ends the run.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= a;
    wb_wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    v = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1)
    begin
      fail_count++;
      results();
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    wb(1'b1, a, d, v);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    wb(1'b0, a, 32'h0, v);
  endtask : rd

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v & m, e);
  endtask : chk_reg

  // Reads status until it moves; a bounded count stands in for a hang.
  task automatic poll(input logic [31:0] p, output logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      rd(8'h3C, v);
      n++;
    end
    while (v === p && n < 200);
    if (v === p)
    begin
      fail_count++;
      results();
    end
  endtask : poll

  function automatic logic [31:0] ramw(input int i);
    return 32'h1111_1111 * (i + 1);
  endfunction : ramw

  function automatic logic [13:0] scaled(input logic [13:0] sf);
    logic [27:0] p;
    p = 28'(core) * 28'(sf);
    return p[27:14];
  endfunction : scaled

  function automatic logic [31:0] seg(input logic [9:0] f, input logic [9:0] b,
                                      input logic [2:0] m);
    return {4'h0, f, b, m, 5'h00};
  endfunction : seg

  // Main sequence: reset, register table, then tone, keying and RAM modes.
  initial
  begin
    repeat (5) @(posedge clk_i);
    chk(frequency_tuning_word, 32'h0);
    chk(32'(scl), 32'h0);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(32'(scl), 32'(scaled(SF_FULL)));
    foreach (rows[i])
    begin
      chk_reg(rows[i].a, 32'hFFFF_FFFF, 32'h0);
      wr(rows[i].a, 32'hFFFF_FFFF);
      chk_reg(rows[i].a, 32'hFFFF_FFFF, rows[i].e);
      wr(rows[i].a, 32'h0);
    end
    wr(8'h0C, 32'hA5C3_0F1E);
    wr(8'h10, 32'h0000_1234);
    repeat (6) @(posedge clk_i);
    chk(frequency_tuning_word, 32'h0);
    dakrs_ctrl_model_inst.update();
    repeat (4) @(posedge clk_i);
    chk(frequency_tuning_word, 32'hA5C3_0F1E);
    chk(32'(phase_offset_word), 32'h1234);
    wr(8'h04, 32'h0000_C123);
    wr(8'h00, 32'h0200_0000);
    dakrs_ctrl_model_inst.update();
    repeat (4) @(posedge clk_i);
    chk(32'(scl), 32'(scaled(14'h0123)));
    // Slow ticks so exactly one step is seen per step code.
    wr(8'h08, 32'h64);
    dakrs_ctrl_model_inst.pins(1'b1, 1'b0, 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h04, {16'h0, 2'(c), 14'h3FFF});
      wr(8'h00, 32'h0300_0000);
      dakrs_ctrl_model_inst.update();
      rd(8'h3C, prev);
      poll(prev, q);
      chk(q & 32'h3FFF, (prev & 32'h3FFF) + (32'h1 << c));
    end
    wr(8'h08, 32'h01);
    wr(8'h04, 32'h0000_C014);
    dakrs_ctrl_model_inst.update();
    repeat (40) @(posedge clk_i);
    chk_reg(8'h3C, 32'h3FFF, 32'h14);
    dakrs_ctrl_model_inst.pins(1'b0, 1'b0, 1'b0);
    repeat (40) @(posedge clk_i);
    chk_reg(8'h3C, 32'h3FFF, 32'h0);
    // RAM words and four segments; profile 3 carries an unused mode code.
    wr(8'h34, 32'h0);
    for (int i = 0; i < 4; i++)
      wr(8'h38, ramw(i));
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h14 + 8'(8 * p), seg(10'd9, 10'(p), (p == 3) ? 3'h5 : 3'h0));
      wr(8'h18 + 8'(8 * p), 32'h2);
    end
    for (int d = 0; d < 2; d++)
    begin
      wr(8'h00, {1'b1, d[0], 30'h0});
      dakrs_ctrl_model_inst.update();
      for (int p = 0; p < 4; p++)
      begin
        dakrs_ctrl_model_inst.pins(1'b0, p[0], p[1]);
        repeat (8) @(posedge clk_i);
        if (d == 0)
          chk(frequency_tuning_word, ramw(p));
        else
          chk(32'(phase_offset_word), 32'(ramw(p) >> 18));
      end
    end
    chk(32'(scl), 32'(scaled(SF_FULL)));
    wr(8'h14, seg(10'd3, 10'd0, 3'h1));
    wr(8'h00, 32'h8000_0000);
    dakrs_ctrl_model_inst.pins(1'b0, 1'b0, 1'b0);
    dakrs_ctrl_model_inst.update();
    repeat (30) @(posedge clk_i);
    chk_reg(8'h3C, 32'h03FF_0000, 32'h0003_0000);
    chk(frequency_tuning_word, ramw(3));
    wr(8'h00, 32'h8000_0004);
    dakrs_ctrl_model_inst.update();
    repeat (30) @(posedge clk_i);
    chk_reg(8'h3C, 32'h03FF_0000, 32'h0);
    chk(frequency_tuning_word, ramw(0));
    wr(8'h14, seg(10'd3, 10'd0, 3'h2));
    dakrs_ctrl_model_inst.pins(1'b0, 1'b1, 1'b1);
    dakrs_ctrl_model_inst.update();
    repeat (30) @(posedge clk_i);
    chk_reg(8'h3C, 32'h03FF_0000, 32'h0003_0000);
    dakrs_ctrl_model_inst.pins(1'b0, 1'b0, 1'b1);
    repeat (30) @(posedge clk_i);
    chk_reg(8'h3C, 32'h03FF_0000, 32'h0);
    results();
  end
endmodule : tb_dakrs_core
